// file: hdl/wdc_pkg.sv
// constants, register map and field layout of the watchdog control block
// assumes one 100 MHz clock and a 32-bit AHB-Lite slave port
//
// How it works
// - level one: starts off, enable freely
// - level one: window write sets enable, select
// - level two: always enabled, reads one
// - level two: window write changes select only
// - level two: never disabled by any sequence
// - hardware clears unlock four cycles later
// - enable clears only while unlocked or on any reset event
// - select changes only while unlocked or on any reset event
// - select gives 16K doubling to 2048K
// - control bits seven to five read zero
// - bit four set by debug-port reset
// - bit three set by watchdog reset
// - bit two set by brown-out reset
// - bit one set by pin reset
// - bit zero set at power-on only
// - enable one starts, zero stops dog
// - counter on own oscillator, restarts
// - fuse selects safety level
// - timeout gives one-cycle chip reset
package wdc_pkg;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CAUSE   = 8'h04;
  localparam int         ADDR_W       = 8;

  // -------------------------------------------------------------------------
  // watchdog_control fields
  // -------------------------------------------------------------------------
  localparam int SEL_LSB    = 0;
  localparam int SEL_W      = 3;
  localparam int BIT_ON     = 3;
  localparam int BIT_UNLOCK = 4;

  // -------------------------------------------------------------------------
  // reset_cause_status fields
  // -------------------------------------------------------------------------
  localparam int BIT_POWER = 0;
  localparam int BIT_PIN   = 1;
  localparam int BIT_DROP  = 2;
  localparam int BIT_DOG   = 3;
  localparam int BIT_DEBUG = 4;
  localparam int CAUSE_W   = 5;

  localparam logic [SEL_W-1:0]   SEL_RESET   = 3'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int         CLK_HZ         = 100_000_000;
  localparam int         OSC_HZ         = 1_000_000;
  localparam int         WINDOW_CYCLES  = 4;
  localparam logic [2:0] WINDOW_LOAD    = 3'(WINDOW_CYCLES);
  localparam int         TIMEOUT_BASE   = 16384;
  localparam int         DOG_CNT_W      = 22;

  // -------------------------------------------------------------------------
  // bus
  // -------------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// file: hdl/wdc_dog_counter.sv
// watchdog time-out counter, counts ticks of the watchdog oscillator
// assumes osc_tick is a one-cycle pulse synchronous to hclk
`timescale 1ns/1ns
`default_nettype none

module wdc_dog_counter #(
  parameter int TIMEOUT_BASE = wdc_pkg::TIMEOUT_BASE,
  parameter int CNT_W        = wdc_pkg::DOG_CNT_W
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      run,
  input  wire logic                      restart,
  input  wire logic                      osc_tick,
  input  wire logic [wdc_pkg::SEL_W-1:0] sel,
  output logic                           expire
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;

  // ---------------------------------------------------------------------------
  // time-out length, doubling per code
  // ---------------------------------------------------------------------------
  assign limit = CNT_W'(TIMEOUT_BASE << sel);

  // ---------------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (restart || !run) begin
      count <= '0;
    end else if (osc_tick) begin
      if (count >= limit - CNT_W'(1)) begin
        count <= '0;
      end else begin
        count <= count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      expire <= 1'b0;
    end else begin
      expire <= run && !restart && osc_tick && (count >= limit - CNT_W'(1));
    end
  end

endmodule

`default_nettype wire

// file: hdl/wdc_top.sv
// watchdog control block: timed change sequence, time-out counter, reset causes
// assumes hresetn is the power-on reset and the other reset causes
// arrive as one-cycle pulses synchronous to hclk
`timescale 1ns/1ns
`default_nettype none

module wdc_top #(
  parameter int TIMEOUT_BASE = wdc_pkg::TIMEOUT_BASE
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // device side
  input  wire logic        safety_level_fuse,
  input  wire logic        osc_tick,
  input  wire logic        dog_restart,
  input  wire logic        debug_reset_event,
  input  wire logic        supply_drop_event,
  input  wire logic        pin_reset_event,
  output logic             chip_reset_pulse,
  output logic             dog_running
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic                                 dp_valid;
  logic                                 dp_write;
  logic [wdc_pkg::ADDR_W-1:0]           dp_addr;
  logic                                 rd_wait;
  logic                                 addr_take;
  logic                                 wr_apply;
  logic                                 wr_control;
  logic                                 wr_cause;
  logic                                 level_two;
  logic                                 dog_on_bit;
  logic                                 change_unlock_bit;
  logic [2:0]                           window_left;
  logic [wdc_pkg::SEL_W-1:0]            timeout_select;
  logic [wdc_pkg::CAUSE_W-1:0]          reset_cause_status;
  logic [wdc_pkg::CAUSE_W-1:0]          cause_set;
  logic [wdc_pkg::CAUSE_W-1:0]          cause_keep;
  logic [wdc_pkg::CAUSE_W-1:0]          next_cause;
  logic [7:0]                           watchdog_control;
  logic                                 w_on;
  logic                                 w_unlock;
  logic [wdc_pkg::SEL_W-1:0]            w_sel;
  logic                                 opening;
  logic                                 chip_reset_event;
  logic                                 dog_expire;
  logic                                 dog_effective;
  logic                                 next_on;
  logic [wdc_pkg::SEL_W-1:0]            next_sel;

  // ---------------------------------------------------------------------------
  // ahb-lite address and data phase
  // ---------------------------------------------------------------------------
  assign addr_take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= '0;
    end else if (hready) begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[wdc_pkg::ADDR_W-1:0];
    end
  end

  // reads take one wait state so the data comes from a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= addr_take && !hwrite;
    end
  end

  assign hreadyout = !rd_wait;
  assign hresp     = wdc_pkg::HRESP_OKAY;

  assign wr_apply   = dp_valid && dp_write;
  assign wr_control = wr_apply && (dp_addr == wdc_pkg::ADDR_CONTROL);
  assign wr_cause   = wr_apply && (dp_addr == wdc_pkg::ADDR_CAUSE);

  assign w_on     = hwdata[wdc_pkg::BIT_ON];
  assign w_unlock = hwdata[wdc_pkg::BIT_UNLOCK];
  assign w_sel    = hwdata[wdc_pkg::SEL_LSB +: wdc_pkg::SEL_W];

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  assign watchdog_control = {3'h0, change_unlock_bit, dog_effective, timeout_select};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_wait) begin
      unique case (dp_addr)
        wdc_pkg::ADDR_CONTROL: hrdata <= {24'h0, watchdog_control};
        wdc_pkg::ADDR_CAUSE:   hrdata <= {27'h0, reset_cause_status};
        default:               hrdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // safety level and chip reset events
  // ---------------------------------------------------------------------------
  assign level_two        = safety_level_fuse;
  assign chip_reset_event = dog_expire || debug_reset_event || supply_drop_event || pin_reset_event;
  assign dog_effective    = dog_on_bit || level_two;
  assign dog_running      = dog_effective;
  assign chip_reset_pulse = dog_expire;

  // ---------------------------------------------------------------------------
  // change window
  // ---------------------------------------------------------------------------
  assign opening = wr_control && w_unlock && w_on;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      change_unlock_bit <= 1'b0;
      window_left       <= '0;
    end else if (chip_reset_event) begin
      change_unlock_bit <= 1'b0;
      window_left       <= '0;
    end else if (opening) begin
      change_unlock_bit <= 1'b1;
      window_left       <= wdc_pkg::WINDOW_LOAD;
    end else if (wr_control && change_unlock_bit) begin
      change_unlock_bit <= 1'b0;
      window_left       <= '0;
    end else if (window_left != '0) begin
      window_left       <= window_left - 3'h1;
      change_unlock_bit <= (window_left != 3'h1);
    end
  end

  // ---------------------------------------------------------------------------
  // enable and time-out select
  // ---------------------------------------------------------------------------
  always_comb begin
    next_on  = dog_on_bit;
    next_sel = timeout_select;
    if (wr_control) begin
      if (change_unlock_bit && !w_unlock) begin
        next_sel = w_sel;
        next_on  = level_two ? 1'b1 : w_on;
      end else if (w_on) begin
        next_on = 1'b1;
      end
      // otherwise a locked write leaves both untouched
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dog_on_bit     <= 1'b0;
      timeout_select <= wdc_pkg::SEL_RESET;
    end else if (chip_reset_event) begin
      dog_on_bit     <= 1'b0;
      timeout_select <= wdc_pkg::SEL_RESET;
    end else begin
      dog_on_bit     <= next_on;
      timeout_select <= next_sel;
    end
  end

  // ---------------------------------------------------------------------------
  // reset cause flags, set wins over clear
  // ---------------------------------------------------------------------------
  assign cause_set[wdc_pkg::BIT_POWER] = 1'b0;
  assign cause_set[wdc_pkg::BIT_PIN]   = pin_reset_event;
  assign cause_set[wdc_pkg::BIT_DROP]  = supply_drop_event;
  assign cause_set[wdc_pkg::BIT_DOG]   = dog_expire;
  assign cause_set[wdc_pkg::BIT_DEBUG] = debug_reset_event;

  assign cause_keep = wr_cause ? hwdata[wdc_pkg::CAUSE_W-1:0] : '1;
  assign next_cause = (reset_cause_status & cause_keep) | cause_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_cause_status <= wdc_pkg::CAUSE_RESET;
    end else begin
      reset_cause_status <= next_cause;
    end
  end

  // ---------------------------------------------------------------------------
  // time-out counter
  // ---------------------------------------------------------------------------
  wdc_dog_counter #(
    .TIMEOUT_BASE (TIMEOUT_BASE),
    .CNT_W        (wdc_pkg::DOG_CNT_W)
  ) u_counter (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (dog_effective),
    .restart  (dog_restart || chip_reset_event),
    .osc_tick (osc_tick),
    .sel      (timeout_select),
    .expire   (dog_expire)
  );

endmodule

`default_nettype wire

// file: dv/wdc_properties.sv
// assertions on the ports of the watchdog control block
// assumes hready is fed back from hreadyout by the bench
`timescale 1ns/1ns
`default_nettype none

module wdc_props #(
  parameter int TIMEOUT_BASE = wdc_pkg::TIMEOUT_BASE
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic [31:0] hrdata,
  input  wire logic        safety_level_fuse,
  input  wire logic        osc_tick,
  input  wire logic        dog_restart,
  input  wire logic        debug_reset_event,
  input  wire logic        supply_drop_event,
  input  wire logic        pin_reset_event,
  input  wire logic        chip_reset_pulse,
  input  wire logic        dog_running
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic rd_phase;
  logic rd_ctl;
  assign take = hsel & hready & htrans[1];
  // ---------------------------------------------------------------------
  // read data phase tracking
  // ---------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_phase <= 1'b0;
      rd_ctl   <= 1'b0;
    end else if (take) begin
      rd_phase <= !hwrite;
      rd_ctl   <= haddr[7:0] == wdc_pkg::ADDR_CONTROL;
    end else if (hreadyout) begin
      rd_phase <= 1'b0;
    end
  end
  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  a_resp_okay: assert property (hresp == wdc_pkg::HRESP_OKAY) else $error("error response");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  a_pulse_single: assert property (chip_reset_pulse |=> !chip_reset_pulse) else $error("pulse too long");
  a_fuse_forces_on: assert property (safety_level_fuse |-> dog_running) else $error("dog off at level two");
  a_idle_no_pulse: assert property ((!dog_running) [*3] |-> !chip_reset_pulse) else $error("pulse while off");
  a_pulse_clears_on: assert property (chip_reset_pulse |-> ##[1:2] dog_running == safety_level_fuse)
    else $error("enable kept after reset");
  a_reserved_zero: assert property (rd_phase && hreadyout |-> hrdata[31:5] == 27'h0) else $error("reserved bits set");
  a_level_two_reads: assert property (rd_phase && hreadyout && rd_ctl && safety_level_fuse |-> hrdata[3])
    else $error("enable reads zero");
  c_timeout: cover property (chip_reset_pulse);
  c_read: cover property (rd_phase && hreadyout && rd_ctl);
  c_level_two: cover property (safety_level_fuse && take);
endmodule

`default_nettype wire

// file: dv/wdc_top_tb.sv
// self-checking bench for the watchdog control block
// assumes a single AHB-Lite slave, hready taken from hreadyout
`timescale 1ns/1ns
`default_nettype none

module wdc_top_tb;
  localparam int TB_BASE = 4;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fuse = 1'b0;
  logic        tick = 1'b0, restart = 1'b0, hreadyout, hresp, pulse, running;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  ev = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, exp_c;
  int          n_errors = 0, n_checks = 0, n;
  bit          seen;
  always #5 hclk = ~hclk;
  wdc_top #(.TIMEOUT_BASE(TB_BASE)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .safety_level_fuse(fuse), .osc_tick(tick), .dog_restart(restart),
    .debug_reset_event(ev[2]), .supply_drop_event(ev[1]), .pin_reset_event(ev[0]),
    .chip_reset_pulse(pulse), .dog_running(running));
  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_rdy;
    logic r;
    for (int i = 0; i < 20; i++) begin
      @(negedge hclk);
      r  = hreadyout;
      rd = hrdata;
      @(posedge hclk);
      if (r === 1'b1) return;
    end
    n_errors++;
    test_done;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= wdc_pkg::HTRANS_NONSEQ; hwrite <= w; haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask
  task automatic pulse_in(input int k);
    if (k == 0) tick <= 1'b1;
    else if (k == 1) restart <= 1'b1;
    else ev <= 3'(k >> 2);
    @(posedge hclk);
    tick <= 1'b0; restart <= 1'b0; ev <= 3'h0;
    @(negedge hclk);
    seen = seen | (pulse === 1'b1);
    @(posedge hclk);
  endtask
  task automatic por(input logic f);
    hresetn <= 1'b0; fuse <= f;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  // ---------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------
  initial begin
    por(1'b0);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h0);
    rdc(wdc_pkg::ADDR_CAUSE, 32'h1);
    rdc(8'h08, 32'h0);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'hef);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h08);
    chk("running", 1, running);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h0);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h18);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h18);
    repeat (6) @(posedge hclk);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h05);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h18);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h05);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h05);
    chk("running", 0, running);
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h18);
      bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h08 | s);
      rdc(wdc_pkg::ADDR_CONTROL, 32'h08 | s);
      seen = 0;
      repeat (2) pulse_in(0);
      pulse_in(1);
      n = 0;
      while (!seen && n < 600) begin
        pulse_in(0);
        n++;
      end
      chk("ticks", TB_BASE << s, n);
    end
    rdc(wdc_pkg::ADDR_CONTROL, 32'h0);
    exp_c = 32'h09;
    rdc(wdc_pkg::ADDR_CAUSE, exp_c);
    for (int k = 1; k < 4; k++) begin
      pulse_in(1 << (k + 1));
      exp_c = exp_c | (32'h1 << (k == 3 ? 4 : k));
      rdc(wdc_pkg::ADDR_CAUSE, exp_c);
    end
    bus(1'b1, wdc_pkg::ADDR_CAUSE, 32'h10);
    rdc(wdc_pkg::ADDR_CAUSE, 32'h10);
    por(1'b1);
    rdc(wdc_pkg::ADDR_CAUSE, 32'h01);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h08);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h18);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h03);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h0b);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h18);
    bus(1'b1, wdc_pkg::ADDR_CONTROL, 32'h00);
    rdc(wdc_pkg::ADDR_CONTROL, 32'h08);
    chk("running", 1, running);
    test_done;
  end
endmodule

bind wdc_top wdc_props #(.TIMEOUT_BASE(TIMEOUT_BASE)) i_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .safety_level_fuse, .osc_tick, .dog_restart,
  .debug_reset_event, .supply_drop_event, .pin_reset_event, .chip_reset_pulse, .dog_running);

`default_nettype wire
